// *** hdl/fps_pkg.sv ***
// Purpose: Shared constants, types and helpers of the front panel scanner.
// Assumes: Core clock of 10 MHz; serial frames shifted MSB first.
// Notes:   Cycle counts are derived from times so a clock change is one edit.
package fps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam int unsigned CHAR_TIME_US = 640;  // Dwell of one character
  localparam int unsigned CHAR_CYCLES  = CHAR_TIME_US * CLK_MHZ;
  localparam int unsigned MONO_TIME_US = 50;   // Display interrupt stretch
  localparam int unsigned MONO_CYCLES  = MONO_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_BITS  = 8;
  localparam int unsigned DATA_BITS  = 16;
  localparam int unsigned COL_BITS   = 8;
  localparam int unsigned ROW_BITS   = 4;
  localparam int unsigned SEG7_BITS  = 7;
  localparam int unsigned SEG14_BITS = 14;
  localparam logic [7:0]  LED_ADDR   = 8'hff;  // Frame address of the LED word

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;  // Character index or LED_ADDR
    logic [DATA_BITS-1:0] data;  // Segment pattern or LED bits, 1 = lit
  } fps_frame_t;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int unsigned SY_DATA = 0;
  localparam int unsigned SY_SCLK = 1;
  localparam int unsigned SY_DSTB = 2;
  localparam int unsigned SY_KSTB = 3;
  localparam int unsigned SY_WA   = 4;
  localparam int unsigned SY_WB   = 5;
  localparam int unsigned SY_WCLR = 6;
  localparam int unsigned SYNC_W  = 7;

  // Sequencer of the local display engine
  typedef enum logic [2:0] {
    SEQ_ADDR  = 3'b000,
    SEQ_WRITE = 3'b001,
    SEQ_HOLD  = 3'b010,
    SEQ_FETCH = 3'b011,
    SEQ_STORE = 3'b100
  } fps_seq_t;

  // Rising edge of a synchronised level
  function automatic logic fps_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage

// *** hdl/fps_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are slow compared with the core clock.
// Notes:   A change is passed on only once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module fps_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] clean_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] clean;
  } fps_sync_st_t;

  fps_sync_st_t st;
  fps_sync_st_t next_st;

  // Stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    next_st       = st;
    next_st.s1    = async_in;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.clean = (st.s2 & st.s3) | (st.clean & (st.s2 | st.s3));
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign clean_out = st.clean;

endmodule
`default_nettype wire

// *** hdl/fps_char_mem.sv ***
// Purpose: Character pattern store, one word per display position.
// Assumes: One write port and one read port on the core clock.
// Notes:   Read data is registered, so it trails the read address by one cycle.
`timescale 1ns/1ns
`default_nettype none
module fps_char_mem #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 20,
  parameter int unsigned AW    = 5
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic [AW-1:0]    raddr_in,
  output logic      [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array carries no reset; the all-on pattern masks it until the LED word lands
  always_ff @(posedge clk_in) begin
    if (ce_in && we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Registered read port
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (ce_in) begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule
`default_nettype wire

// *** hdl/fps_front_panel.sv ***
// Purpose: Front panel scanner: serial display/LED/column input, character
//          multiplexing, LED drive, tuning wheel decode and row return.
// Assumes: Host serial clock far slower than the core clock; host holds the
//          strobes low while shifting.
//          Wheel and strobe pulses last three core clocks or more.
// Notes:   The local display engine is a hardware sequencer whose address,
//          read and write strobes are brought out for observation.
//          Unloaded positions show unknown patterns once all-on ends.
//          Row senses are plain wires, not synchronised.
`timescale 1ns/1ns
`default_nettype none
module fps_front_panel #(
  parameter int unsigned NUM_CHARS   = 20,
  parameter int unsigned NUM_WIDE    = 8,
  parameter int unsigned NUM_LEDS    = 12,
  parameter int unsigned CHAR_CYCLES = fps_pkg::CHAR_CYCLES,
  parameter int unsigned MONO_CYCLES = fps_pkg::MONO_CYCLES
) (
  input  wire logic                             ref_clk_in,
  input  wire logic                             rst_n_in,
  input  wire logic                             ce_in,
  input  wire logic                             ser_data_in,
  input  wire logic                             ser_clk_in,
  input  wire logic                             display_load_strobe_in,
  input  wire logic                             column_load_strobe_in,
  input  wire logic                             wheel_a_in,
  input  wire logic                             wheel_b_in,
  input  wire logic                             wheel_irq_clear_in,
  input  wire logic [fps_pkg::ROW_BITS-1:0]     row_sense_in,
  output logic      [fps_pkg::ROW_BITS-1:0]     row_sense_out,
  output logic                                  wheel_step_irq_out,
  output logic                                  wheel_dir_out,
  output logic      [fps_pkg::COL_BITS-1:0]     column_drive_out,
  output logic      [NUM_LEDS-1:0]              led_n_out,
  output logic      [NUM_CHARS-1:0]             char_enable_out,
  output logic      [fps_pkg::SEG7_BITS-1:0]    seg7_out,
  output logic      [fps_pkg::SEG14_BITS-1:0]   seg14_out,
  output logic                                  display_irq_out,
  output logic                                  address_strobe_out,
  output logic                                  read_strobe_n_out,
  output logic                                  write_strobe_n_out
);

  // ----------------------------------------------------------------
  // Local sizes
  // ----------------------------------------------------------------
  // Widths follow the parameters
  localparam int unsigned IDX_W  = (NUM_CHARS > 1) ? $clog2(NUM_CHARS) : 1;
  localparam int unsigned CNT_W  = $clog2(CHAR_CYCLES + 1);
  localparam int unsigned MONO_W = $clog2(MONO_CYCLES + 1);

  // End points, cut to their counters on purpose
  localparam logic [IDX_W-1:0]  LAST_IDX  = IDX_W'(NUM_CHARS - 1);
  localparam logic [CNT_W-1:0]  DWELL_END = CNT_W'(CHAR_CYCLES - 1);
  localparam logic [MONO_W-1:0] MONO_LOAD = MONO_W'(MONO_CYCLES - 1);
  localparam logic [fps_pkg::ADDR_BITS-1:0] CHAR_LIMIT = fps_pkg::ADDR_BITS'(NUM_CHARS);
  localparam logic [IDX_W-1:0]  WIDE_LIMIT = IDX_W'(NUM_WIDE);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Every flop of this module
  typedef struct packed {
    fps_pkg::fps_seq_t                   seq;
    logic [fps_pkg::FRAME_BITS-1:0]      disp_shift;
    logic [fps_pkg::COL_BITS-1:0]        col_shift;
    logic [fps_pkg::SYNC_W-1:0]          prev;
    logic [MONO_W-1:0]                   mono_cnt;
    logic                                disp_irq;
    fps_pkg::fps_frame_t                 frame;
    logic                                all_on;
    logic [IDX_W-1:0]                    char_idx;
    logic [IDX_W-1:0]                    addr_latch;
    logic [CNT_W-1:0]                    dwell;
    logic [fps_pkg::SEG7_BITS-1:0]       seg7;
    logic [fps_pkg::SEG14_BITS-1:0]      seg14;
    logic [NUM_CHARS-1:0]                char_en;
    logic [NUM_LEDS-1:0]                 led_n;
    logic [fps_pkg::COL_BITS-1:0]        col_drive;
    logic                                wheel_irq;
    logic                                wheel_dir;
  } fps_state_t;

  // Registered state and its next value
  fps_state_t                      st;
  fps_state_t                      next_st;
  logic [fps_pkg::SYNC_W-1:0]      sync_raw;
  logic [fps_pkg::SYNC_W-1:0]      sy;

  // Edge events of the synchronised lanes
  logic                            sclk_rise;
  logic                            disp_strobe_rise;
  logic                            keypad_latch_pulse;
  logic                            wheel_a_rise;

  // Character store ports
  logic                            mem_we;
  logic [fps_pkg::DATA_BITS-1:0]   mem_rdata;
  logic [fps_pkg::DATA_BITS-1:0]   pattern;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // All host and wheel pins cross here; none is used before this point
  always_comb begin
    sync_raw                   = '0;
    sync_raw[fps_pkg::SY_DATA] = ser_data_in;
    sync_raw[fps_pkg::SY_SCLK] = ser_clk_in;
    sync_raw[fps_pkg::SY_DSTB] = display_load_strobe_in;
    sync_raw[fps_pkg::SY_KSTB] = column_load_strobe_in;
    sync_raw[fps_pkg::SY_WA]   = wheel_a_in;
    sync_raw[fps_pkg::SY_WB]   = wheel_b_in;
    sync_raw[fps_pkg::SY_WCLR] = wheel_irq_clear_in;
  end

  // One bank for all seven lanes
  fps_sync #(
    .WIDTH     (fps_pkg::SYNC_W)
  ) u_sync (
    .clk_in    (ref_clk_in),
    .rst_n_in  (rst_n_in),
    .ce_in     (ce_in),
    .async_in  (sync_raw),
    .clean_out (sy)
  );

  // Edge events; data lane shares the clock lane's delay so stays aligned
  assign sclk_rise          = fps_pkg::fps_rise(sy[fps_pkg::SY_SCLK], st.prev[fps_pkg::SY_SCLK]);
  assign disp_strobe_rise   = fps_pkg::fps_rise(sy[fps_pkg::SY_DSTB], st.prev[fps_pkg::SY_DSTB]);
  assign keypad_latch_pulse = fps_pkg::fps_rise(sy[fps_pkg::SY_KSTB], st.prev[fps_pkg::SY_KSTB]);
  assign wheel_a_rise       = fps_pkg::fps_rise(sy[fps_pkg::SY_WA], st.prev[fps_pkg::SY_WA]);
  // Lane B is only sampled, never edge-detected

  // ----------------------------------------------------------------
  // Character pattern store
  // ----------------------------------------------------------------
  // Addresses past the last position are dropped
  assign mem_we = (st.seq == fps_pkg::SEQ_STORE) && (st.frame.addr < CHAR_LIMIT);

  // Read port trails the scan index by one cycle
  fps_char_mem #(
    .WIDTH     (fps_pkg::DATA_BITS),
    .DEPTH     (NUM_CHARS),
    .AW        (IDX_W)
  ) u_mem (
    .clk_in    (ref_clk_in),
    .rst_n_in  (rst_n_in),
    .ce_in     (ce_in),
    .we_in     (mem_we),
    .waddr_in  (st.frame.addr[IDX_W-1:0]),
    .wdata_in  (st.frame.data),
    .raddr_in  (st.char_idx),
    .rdata_out (mem_rdata)
  );

  // Until the host's first LED frame the whole panel shows all-on
  assign pattern = st.all_on ? '1 : mem_rdata;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    // Hold every field; remember this cycle's lanes
    next_st      = st;
    next_st.prev = sy;

    // Both shift chains take every host clock rise
    if (sclk_rise) begin
      next_st.disp_shift = {st.disp_shift[fps_pkg::FRAME_BITS-2:0],
                            sy[fps_pkg::SY_DATA]};
      next_st.col_shift  = {st.col_shift[fps_pkg::COL_BITS-2:0],
                            sy[fps_pkg::SY_DATA]};
    end

    // Monostable: times out on its own, or cleared by the read strobe
    // Timeout ends a stretch that no read claims
    if (st.disp_irq) begin
      if (st.mono_cnt != '0) begin
        next_st.mono_cnt = st.mono_cnt - MONO_W'(1);
      end else begin
        next_st.disp_irq = 1'b0;
      end
    end

    // Read strobe resets the monostable
    if (st.seq == fps_pkg::SEQ_FETCH) begin
      next_st.disp_irq = 1'b0;
    end
    // A new strobe wins over the clear in the same cycle
    if (disp_strobe_rise) begin
      next_st.disp_irq = 1'b1;
      next_st.mono_cnt = MONO_LOAD;
    end

    // Column drives change only on the keyboard strobe
    if (keypad_latch_pulse) begin
      next_st.col_drive = st.col_shift;
    end

    // Wheel: one step per rise of lane A; lane B gives the sense
    // Clear is a level: it keeps clearing while held
    if (sy[fps_pkg::SY_WCLR]) begin
      next_st.wheel_irq = 1'b0;
    end

    // A rise in the clearing cycle still sets the flag
    if (wheel_a_rise) begin
      next_st.wheel_irq = 1'b1;
      next_st.wheel_dir = sy[fps_pkg::SY_WB];
    end

    // Dwell counter runs through service cycles so the period stays fixed
    // A frame read at dwell end adds up to three cycles
    if (st.dwell != '1) begin
      next_st.dwell = st.dwell + CNT_W'(1);
    end

    // Engine: address, write, hold, then fetch and store
    unique case (st.seq)
      fps_pkg::SEQ_ADDR: begin
        // Address strobe phase: latch the position being refreshed
        next_st.addr_latch = st.char_idx;
        // Dwell restarts so each position gets equal time
        next_st.dwell      = '0;
        next_st.seq        = fps_pkg::SEQ_WRITE;
      end

      fps_pkg::SEQ_WRITE: begin
        // Write strobe: pattern into its latch, enable moves in one step
        // The first NUM_WIDE positions are 14-segment
        if (st.addr_latch < WIDE_LIMIT) begin
          next_st.seg14 = pattern[fps_pkg::SEG14_BITS-1:0];
        end else begin
          next_st.seg7  = pattern[fps_pkg::SEG7_BITS-1:0];
        end
        next_st.char_en = NUM_CHARS'(1) << st.addr_latch;
        next_st.seq     = fps_pkg::SEQ_HOLD;
      end

      fps_pkg::SEQ_HOLD: begin
        // A pending host frame is serviced without dropping the character
        if (st.disp_irq) begin
          next_st.seq = fps_pkg::SEQ_FETCH;
        end else if (st.dwell >= DWELL_END) begin
          // Next position, wrapping after the last
          next_st.seq      = fps_pkg::SEQ_ADDR;
          next_st.char_idx = (st.char_idx == LAST_IDX) ? '0
                                                       : st.char_idx + IDX_W'(1);
        end
      end

      fps_pkg::SEQ_FETCH: begin
        // Read strobe: parallel read of the display shift chain
        // All stages go over in one cycle
        next_st.frame = fps_pkg::fps_frame_t'(st.disp_shift);
        next_st.seq   = fps_pkg::SEQ_STORE;
      end

      fps_pkg::SEQ_STORE: begin
        // Character words go to the store; the LED word ends the all-on look
        if (st.frame.addr == fps_pkg::LED_ADDR) begin
          next_st.led_n  = ~st.frame.data[NUM_LEDS-1:0];
          next_st.all_on = 1'b0;
        end
        // Other addresses leave no trace here
        next_st.seq = fps_pkg::SEQ_HOLD;
      end

      default: begin
        // Unused codes fall back to the address phase
        next_st.seq = fps_pkg::SEQ_ADDR;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset comes up lit: LEDs low, every segment high, position 0 enabled
  // Clock enable low freezes every field
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st         <= '0;
      st.all_on  <= 1'b1;
      st.seg7    <= '1;
      st.seg14   <= '1;
      st.char_en <= NUM_CHARS'(1);
      st.seq     <= fps_pkg::SEQ_ADDR;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Row senses are wires back to the host; no sampling delay wanted
  assign row_sense_out      = row_sense_in;

  // Host-facing wheel and column outputs
  assign wheel_step_irq_out = st.wheel_irq;
  assign wheel_dir_out      = st.wheel_dir;
  assign column_drive_out   = st.col_drive;

  // Panel drives: LEDs, enables, segment latches
  assign led_n_out          = st.led_n;
  assign char_enable_out    = st.char_en;
  assign seg7_out           = st.seg7;
  assign seg14_out          = st.seg14;

  // Interrupt to the local engine
  assign display_irq_out    = st.disp_irq;

  // Local bus strobes decoded from the sequencer state
  // Read and write are active low, address high
  assign address_strobe_out = (st.seq == fps_pkg::SEQ_ADDR);
  assign read_strobe_n_out  = ~(st.seq == fps_pkg::SEQ_FETCH);
  assign write_strobe_n_out = ~(st.seq == fps_pkg::SEQ_WRITE);

endmodule
`default_nettype wire

// *** sim/fps_front_panel_sva.sv ***
// Purpose: Port checks of the front panel scanner, bound to its top.
// Assumes: Clock enable held high; pin inputs pass a three-flop filter.
// Notes:   Pin-to-output windows allow for that filter latency.
`timescale 1ns/1ns
`default_nettype none
module fps_front_panel_sva #(
  parameter int unsigned NUM_CHARS   = 20,
  parameter int unsigned CHAR_CYCLES = 6400,
  parameter int unsigned MONO_CYCLES = 500
) (
  input wire logic                         ref_clk_in,
  input wire logic                         rst_n_in,
  input wire logic                         display_load_strobe_in,
  input wire logic                         wheel_a_in,
  input wire logic                         wheel_b_in,
  input wire logic                         wheel_irq_clear_in,
  input wire logic [fps_pkg::ROW_BITS-1:0] row_sense_in,
  input wire logic [fps_pkg::ROW_BITS-1:0] row_sense_out,
  input wire logic                         wheel_step_irq_out,
  input wire logic                         wheel_dir_out,
  input wire logic [NUM_CHARS-1:0]         char_enable_out,
  input wire logic                         display_irq_out,
  input wire logic                         address_strobe_out,
  input wire logic                         read_strobe_n_out,
  input wire logic                         write_strobe_n_out
);
  localparam int MONO_MAX = MONO_CYCLES + 4;  // Stretch plus filter slack
  localparam int DWELL_LO = CHAR_CYCLES - 1;
  localparam int DWELL_HI = CHAR_CYCLES + 2;  // Allows two extra cycles; a frame read at dwell end adds up to three
  int   dwell;
  logic armed;
  // ------------
  // Dwell counter
  // ------------
  // First change after reset is skipped, as its start is not aligned
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dwell <= 0;
      armed <= 1'b0;
    end else begin
      dwell <= $changed(char_enable_out) ? 0 : dwell + 1;
      armed <= armed | $changed(char_enable_out);
    end
  end
  // ------------
  // Checks
  // ------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Scan: one position lit, fixed dwell, address strobe then one write
  property p_onehot; $onehot(char_enable_out); endproperty
  a_onehot: assert property (p_onehot) else $error("enable not one-hot");
  property p_dwell;
    $changed(char_enable_out) && armed |-> dwell >= DWELL_LO && dwell <= DWELL_HI;
  endproperty
  a_dwell: assert property (p_dwell) else $error("dwell out of range");
  property p_addr_wr; address_strobe_out |=> !write_strobe_n_out ##1 write_strobe_n_out; endproperty
  a_addr_wr: assert property (p_addr_wr) else $error("write not after address");
  // Display interrupt: set by the strobe, cleared by the read or timeout
  property p_disp_set; $rose(display_load_strobe_in) |-> ##[2:7] display_irq_out; endproperty
  a_disp_set: assert property (p_disp_set) else $error("no display irq");
  property p_disp_max; $rose(display_irq_out) |-> ##[1:MONO_MAX] !display_irq_out; endproperty
  a_disp_max: assert property (p_disp_max) else $error("display irq too long");
  property p_disp_clr; !read_strobe_n_out |=> !display_irq_out; endproperty
  a_disp_clr: assert property (p_disp_clr) else $error("read left irq set");
  // Wheel: set on lane A, direction from lane B, held until cleared
  property p_step_set; $rose(wheel_a_in) |-> ##[2:7] wheel_step_irq_out; endproperty
  a_step_set: assert property (p_step_set) else $error("no step irq");
  property p_step_dir; $rose(wheel_step_irq_out) |-> wheel_dir_out == $past(wheel_b_in, 6); endproperty
  a_step_dir: assert property (p_step_dir) else $error("wrong direction");
  property p_step_hold; $fell(wheel_step_irq_out) |-> $past(wheel_irq_clear_in, 2); endproperty
  a_step_hold: assert property (p_step_hold) else $error("step irq dropped");
  property p_rows; row_sense_out == row_sense_in; endproperty
  a_rows: assert property (p_rows) else $error("row return differs");
endmodule
bind fps_front_panel fps_front_panel_sva #(.NUM_CHARS(NUM_CHARS),
  .CHAR_CYCLES(CHAR_CYCLES), .MONO_CYCLES(MONO_CYCLES)) u_sva (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .display_load_strobe_in(display_load_strobe_in), .wheel_a_in(wheel_a_in),
  .wheel_b_in(wheel_b_in), .wheel_irq_clear_in(wheel_irq_clear_in),
  .row_sense_in(row_sense_in), .row_sense_out(row_sense_out),
  .wheel_step_irq_out(wheel_step_irq_out), .wheel_dir_out(wheel_dir_out),
  .char_enable_out(char_enable_out), .display_irq_out(display_irq_out),
  .address_strobe_out(address_strobe_out), .read_strobe_n_out(read_strobe_n_out),
  .write_strobe_n_out(write_strobe_n_out));
`default_nettype wire

// *** sim/fps_host_model.sv ***
// Purpose: Host end of the panel link: serial frames, clock, strobes.
// Assumes: Core clock of 100 ns; serial clock of 800 ns.
// Notes:   Data shows the inverse of the last bit between frames.
`timescale 1ns/1ns
`default_nettype none
module fps_host_model (
  input  wire logic clk_in,
  output logic      ser_data_out,
  output logic      ser_clk_out,
  output logic      disp_stb_out,
  output logic      col_stb_out
);
  // ------------
  // Link drive
  // ------------
  // Idle link: clock and strobes low between frames; strobes also low while shifting
  initial begin
    ser_data_out = 1'b0;
    ser_clk_out  = 1'b0;
    disp_stb_out = 1'b0;
    col_stb_out  = 1'b0;
  end
  // One bit: data set with the clock low, 400 ns per level
  task automatic shift_bit(input logic b);
    ser_data_out = b;
    repeat (4) @(posedge clk_in);
    #1 ser_clk_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 ser_clk_out = 1'b0;
  endtask
  // Strobe after the last bit; a long pulse so the filter cannot drop it
  task automatic strobe(input logic disp);
    repeat (4) @(posedge clk_in);
    #1 {disp_stb_out, col_stb_out} = {disp, !disp};
    repeat (8) @(posedge clk_in);
    #1 {disp_stb_out, col_stb_out} = 2'b00;
    ser_data_out = !ser_data_out;
  endtask
  // Display or LED frame, most significant bit first
  task automatic send_frame(input fps_pkg::fps_frame_t f);
    for (int i = 23; i >= 0; i--) begin
      shift_bit(f[i]);
    end
    strobe(1'b1);
  endtask
  // Keypad column pattern, most significant bit first
  task automatic send_cols(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(c[i]);
    end
    strobe(1'b0);
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench of the front panel scanner.
// Assumes: Clock enable tied high; the host model drives the link.
// Notes:   Dwell and stretch are shortened to keep scan rounds short.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int unsigned DWELL = 40;
  localparam int unsigned MONO  = 8;
  logic        clk, rst_n, wa, wb, wclr, step_irq, dir;
  logic        disp_irq, astb, rd_n, wr_n, sdata, sclk, dstb, kstb;
  logic [3:0]  rows, rows_ret;
  logic [7:0]  cols;
  logic [11:0] led_n;
  logic [19:0] chars;
  logic [6:0]  seg7;
  logic [13:0] seg14;
  int          fail_count = 0;
  int          check_count = 0;
  fps_front_panel #(.CHAR_CYCLES(DWELL), .MONO_CYCLES(MONO)) dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .ser_data_in(sdata),
    .ser_clk_in(sclk), .display_load_strobe_in(dstb), .column_load_strobe_in(kstb),
    .wheel_a_in(wa), .wheel_b_in(wb), .wheel_irq_clear_in(wclr), .row_sense_in(rows),
    .row_sense_out(rows_ret), .wheel_step_irq_out(step_irq), .wheel_dir_out(dir),
    .column_drive_out(cols), .led_n_out(led_n), .char_enable_out(chars),
    .seg7_out(seg7), .seg14_out(seg14), .display_irq_out(disp_irq),
    .address_strobe_out(astb), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n));
  fps_host_model host (.clk_in(clk), .ser_data_out(sdata), .ser_clk_out(sclk),
    .disp_stb_out(dstb), .col_stb_out(kstb));
  // ------------
  // Helpers
  // ------------
  // Inputs change and outputs are read 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // Next fresh refresh of one position, bounded by about two scan rounds
  task automatic wait_char(input int idx);
    int n;
    for (n = 0; n < 900 && chars[idx] === 1'b1; n++) tick(1);
    for (n = 0; n < 900 && chars[idx] !== 1'b1; n++) tick(1);
    check(chars[idx], 1'b1);
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_power_on;
    tick(5);
    check(led_n, 12'h000);
    wait_char(3);
    check(seg7, 7'h7f);
    check(seg14, 14'h3fff);
    check(cols, 8'h00);
  endtask
  // Characters first; all stay lit until the LED word lands
  task automatic t_display;
    host.send_frame({8'h00, 16'hea5c});
    host.send_frame({8'h0b, 16'h805b});
    tick(4);
    check(disp_irq, 1'b0);
    wait_char(0);
    check(seg14, 14'h3fff);
    host.send_frame({fps_pkg::LED_ADDR, 16'h0a53});
    tick(4);
    check(led_n, 12'h5ac);
    wait_char(0);
    check(seg14, 14'h2a5c);
    wait_char(11);
    check(seg7, 7'h5b);
    check(cols, 8'h00);
  endtask
  task automatic t_columns;
    for (int k = 0; k < 2; k++) begin
      host.send_cols(k ? 8'h3c : 8'ha5);
      tick(4);
      check(cols, k ? 8'h3c : 8'ha5);
    end
  endtask
  // Lane B is settled well before lane A rises, as in quadrature
  task automatic t_wheel;
    for (int d = 0; d < 2; d++) begin
      wb = d[0];
      tick(10);
      wa = 1'b1;
      tick(10);
      check(dir, d[0]);
      wa = 1'b0;
      tick(10);
      check(step_irq, 1'b1);
      host.send_frame({8'h0c, d[0] ? 16'h0007 : 16'h0005});
      wait_char(12);
      check(seg7, d[0] ? 7'h07 : 7'h05);
      wclr = 1'b1;
      tick(10);
      wclr = 1'b0;
      tick(10);
      check(step_irq, 1'b0);
    end
  endtask
  task automatic t_rows;
    for (int v = 0; v < 16; v++) begin
      rows = v[3:0];
      tick(1);
      check(rows_ret, v);
    end
  endtask
  // ------------
  // Run
  // ------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    wa    = 1'b0;
    wb    = 1'b0;
    wclr  = 1'b0;
    rows  = 4'h0;
    tick(20);
    rst_n = 1'b1;
    t_power_on();
    t_display();
    t_columns();
    t_wheel();
    t_rows();
    give_verdict();
  end
  // Watchdog far beyond the expected run of some 4000 cycles
  initial begin
    #2000000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
